// file: include/lvd_cfg.svh
// Purpose: Constants for the supply monitor control block
// Assumes: 250 MHz system clock, AXI4-Lite register access
// Notes: Operation summary follows
`ifndef LVD_CFG_SVH
`define LVD_CFG_SVH

`define SYS_CLK_MHZ 250
`define IRQ_DELAY_NS 10000
`define IRQ_DELAY_CYC ((`IRQ_DELAY_NS * `SYS_CLK_MHZ + 999) / 1000)
`define TIMER_W 12

// Register byte offsets
`define OFFS_CONTROL 8'h00
`define OFFS_STATUS 8'h04
`define OFFS_MASK 8'h08

// Control register fields
`define CTRL_THR_LSB 0
`define CTRL_THR_MSB 2
`define CTRL_REF_BIT 3
`define CTRL_EN_BIT 4
`define CTRL_FLAG_BIT 5
`define CTRL_RESET 8'h00

// Status and mask fields
`define ST_IRQ_BIT 0
`define ST_RISE_BIT 1
`define ST_W 2
`define ST_RESET 2'h0

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: include/lvd_pkg.sv
// Purpose: Shared types for the supply monitor control block
// Assumes: Constants come from lvd_cfg.svh
// Notes: Write channel states are one-hot
package lvd_pkg;
	typedef logic [1:0] resp_type;
	typedef logic [2:0] thr_type;
	typedef enum logic [1:0] {
		WR_IDLE = 2'b01,
		WR_RESP = 2'b10
	} wr_state_type;
endpackage

// file: src/irq_delay_timer.sv
// Purpose: Counts a continuous run of cycles and pulses once at the end
// Assumes: run comes from the system clock domain
// Notes: Any drop of run restarts the count
`include "lvd_cfg.svh"
module irq_delay_timer (
	input wire logic clk,
	input wire logic rst,
	input wire logic run,
	output logic done
);
	logic [`TIMER_W-1:0] cnt_r, cnt_nxt;
	logic done_r, done_nxt;
	localparam logic [`TIMER_W-1:0] LAST = `TIMER_W'(`IRQ_DELAY_CYC - 1);

	// Count while run holds; pulse once when the last cycle is reached
	always_comb begin
		cnt_nxt = cnt_r;
		done_nxt = 1'b0;
		if (!run) begin
			cnt_nxt = '0;
		end else if (cnt_r < LAST) begin
			cnt_nxt = cnt_r + 1'b1;
		end else if (cnt_r == LAST) begin
			cnt_nxt = cnt_r + 1'b1; // Parks past the end so the pulse is single
			done_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_r <= '0;
			done_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			done_r <= done_nxt;
		end
	end

	assign done = done_r;
endmodule // irq_delay_timer

// file: src/supply_monitor_ctrl.sv
// Purpose: Register and flag logic around the low-supply comparator
// Assumes: COMP_LOW is asynchronous; SLEEP_MODE and IDLE_MODE are on SYS_CLK
// Notes: Analogue comparator and reference live outside; this drives their controls
`include "lvd_cfg.svh"
module supply_monitor_ctrl (
	input wire logic SYS_CLK,
	input wire logic RST,
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output lvd_pkg::resp_type S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output lvd_pkg::resp_type S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic COMP_LOW,
	input wire logic SLEEP_MODE,
	input wire logic IDLE_MODE,
	output logic DETECTOR_ON,
	output logic REFERENCE_ON,
	output lvd_pkg::thr_type THRESHOLD_SEL,
	output logic WAKE_REQ,
	output logic IRQ
);
	import lvd_pkg::*;

	// Address decode shared by both channels
	function automatic logic known_addr(input logic [7:0] a);
		return (a == `OFFS_CONTROL) || (a == `OFFS_STATUS) || (a == `OFFS_MASK);
	endfunction

	// Comparator synchroniser; first stage is read only by the second
	logic comp_meta_r, comp_sync_r;

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			comp_meta_r <= 1'b0;
			comp_sync_r <= 1'b0;
		end else begin
			comp_meta_r <= COMP_LOW;
			comp_sync_r <= comp_meta_r;
		end
	end

	// Control register state
	logic det_en_r, det_en_nxt;
	logic ref_en_r, ref_en_nxt;
	thr_type thr_r, thr_nxt;
	logic [`ST_W-1:0] status_r, status_nxt;
	logic [`ST_W-1:0] mask_r, mask_nxt;
	logic flag_r, flag_nxt;
	logic active;
	logic delay_done;

	// Comparator is only meaningful while powered and awake
	assign active = det_en_r && !SLEEP_MODE;

	// Flag follows the comparator with no filter, so it may chatter near the trip point
	assign flag_nxt = active && comp_sync_r;

	irq_delay_timer u_timer (
		.clk(SYS_CLK),
		.rst(RST),
		.run(flag_r),
		.done(delay_done)
	);

	// Write channel
	wr_state_type wr_state_r, wr_state_nxt;
	logic aw_have_r, aw_have_nxt;
	logic w_have_r, w_have_nxt;
	logic [7:0] aw_addr_r, aw_addr_nxt;
	logic [31:0] w_data_r, w_data_nxt;
	logic w_lane0_r, w_lane0_nxt;
	logic awready_r, awready_nxt;
	logic wready_r, wready_nxt;
	logic bvalid_r, bvalid_nxt;
	resp_type bresp_r, bresp_nxt;
	logic wr_fire;

	assign wr_fire = (wr_state_r == WR_IDLE) && aw_have_r && w_have_r;

	// Address and data are taken in either order; the write happens once both are held
	always_comb begin
		wr_state_nxt = wr_state_r;
		aw_have_nxt = aw_have_r;
		w_have_nxt = w_have_r;
		aw_addr_nxt = aw_addr_r;
		w_data_nxt = w_data_r;
		w_lane0_nxt = w_lane0_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		if (S_AXI_AWVALID && awready_r) begin
			aw_have_nxt = 1'b1;
			aw_addr_nxt = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && wready_r) begin
			w_have_nxt = 1'b1;
			w_data_nxt = S_AXI_WDATA;
			w_lane0_nxt = S_AXI_WSTRB[0];
		end
		unique case (wr_state_r)
			WR_IDLE: begin
				if (wr_fire) begin
					bvalid_nxt = 1'b1;
					bresp_nxt = known_addr(aw_addr_r) ? `RESP_OKAY : `RESP_SLVERR;
					wr_state_nxt = WR_RESP;
				end
			end
			WR_RESP: begin
				if (S_AXI_BREADY) begin
					bvalid_nxt = 1'b0;
					aw_have_nxt = 1'b0;
					w_have_nxt = 1'b0;
					wr_state_nxt = WR_IDLE;
				end
			end
		endcase
		awready_nxt = !aw_have_nxt;
		wready_nxt = !w_have_nxt;
	end

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			wr_state_r <= WR_IDLE;
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r <= 32'h0000_0000;
			w_lane0_r <= 1'b0;
			awready_r <= 1'b0;
			wready_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= `RESP_OKAY;
		end else begin
			wr_state_r <= wr_state_nxt;
			aw_have_r <= aw_have_nxt;
			w_have_r <= w_have_nxt;
			aw_addr_r <= aw_addr_nxt;
			w_data_r <= w_data_nxt;
			w_lane0_r <= w_lane0_nxt;
			awready_r <= awready_nxt;
			wready_r <= wready_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
		end
	end

	// Read channel: one outstanding read, answered the cycle after it is taken
	logic arready_r, arready_nxt;
	logic rvalid_r, rvalid_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	resp_type rresp_r, rresp_nxt;
	logic rd_take;
	logic rd_status;

	assign rd_take = S_AXI_ARVALID && arready_r;
	assign rd_status = rd_take && (S_AXI_ARADDR == `OFFS_STATUS);

	always_comb begin
		rvalid_nxt = rvalid_r;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		if (rvalid_r && S_AXI_RREADY) begin
			rvalid_nxt = 1'b0;
		end
		if (rd_take) begin
			rvalid_nxt = 1'b1;
			rresp_nxt = known_addr(S_AXI_ARADDR) ? `RESP_OKAY : `RESP_SLVERR;
			rdata_nxt = 32'h0000_0000;
			unique case (S_AXI_ARADDR)
				`OFFS_CONTROL: begin
					// Upper two bits stay zero from the cleared word
					rdata_nxt[`CTRL_FLAG_BIT] = flag_r;
					rdata_nxt[`CTRL_EN_BIT] = det_en_r;
					rdata_nxt[`CTRL_REF_BIT] = ref_en_r;
					rdata_nxt[`CTRL_THR_MSB:`CTRL_THR_LSB] = thr_r;
				end
				`OFFS_STATUS: rdata_nxt[`ST_W-1:0] = status_r;
				`OFFS_MASK: rdata_nxt[`ST_W-1:0] = mask_r;
				default: rdata_nxt = 32'h0000_0000;
			endcase
		end
		arready_nxt = !rvalid_nxt;
	end

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= `RESP_OKAY;
		end else begin
			arready_r <= arready_nxt;
			rvalid_r <= rvalid_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
		end
	end

	// Register updates, sticky events and wake-up
	logic wr_ctrl, wr_status, wr_mask;
	logic flag_rise;
	logic irq_set;
	logic irq_r, irq_nxt;
	logic wake_r, wake_nxt;

	assign wr_ctrl = wr_fire && w_lane0_r && (aw_addr_r == `OFFS_CONTROL);
	assign wr_status = wr_fire && w_lane0_r && (aw_addr_r == `OFFS_STATUS);
	assign wr_mask = wr_fire && w_lane0_r && (aw_addr_r == `OFFS_MASK);
	assign flag_rise = flag_nxt && !flag_r;
	// Only a fresh 0 to 1 change counts, so a preset flag blocks wake-ups
	assign irq_set = delay_done && !status_r[`ST_IRQ_BIT];

	always_comb begin
		det_en_nxt = det_en_r;
		ref_en_nxt = ref_en_r;
		thr_nxt = thr_r;
		mask_nxt = mask_r;
		status_nxt = status_r;
		if (wr_ctrl) begin
			det_en_nxt = w_data_r[`CTRL_EN_BIT];
			ref_en_nxt = w_data_r[`CTRL_REF_BIT];
			thr_nxt = w_data_r[`CTRL_THR_MSB:`CTRL_THR_LSB];
		end
		if (wr_mask) begin
			mask_nxt = w_data_r[`ST_W-1:0];
		end
		// A read clears; a write of one presets; a new event wins over both
		if (rd_status) begin
			status_nxt = `ST_RESET;
		end
		if (wr_status) begin
			status_nxt = status_nxt | w_data_r[`ST_W-1:0];
		end
		if (delay_done) begin
			status_nxt[`ST_IRQ_BIT] = 1'b1;
		end
		if (flag_rise) begin
			status_nxt[`ST_RISE_BIT] = 1'b1;
		end
		irq_nxt = |(status_nxt & mask_nxt);
		// Wake is requested only from a low-power mode, on a new flag setting
		wake_nxt = irq_set && (SLEEP_MODE || IDLE_MODE);
	end

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			det_en_r <= 1'b0;
			ref_en_r <= 1'b0;
			thr_r <= 3'h0;
			mask_r <= `ST_RESET;
			status_r <= `ST_RESET;
			flag_r <= 1'b0;
			irq_r <= 1'b0;
			wake_r <= 1'b0;
		end else begin
			det_en_r <= det_en_nxt;
			ref_en_r <= ref_en_nxt;
			thr_r <= thr_nxt;
			mask_r <= mask_nxt;
			status_r <= status_nxt;
			flag_r <= flag_nxt;
			irq_r <= irq_nxt;
			wake_r <= wake_nxt;
		end
	end

	// Analogue control outputs, registered so they never glitch
	logic det_on_r, det_on_nxt;
	logic ref_on_r, ref_on_nxt;

	always_comb begin
		det_on_nxt = det_en_nxt && !SLEEP_MODE;
		ref_on_nxt = ref_en_nxt || det_en_nxt;
	end

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			det_on_r <= 1'b0;
			ref_on_r <= 1'b0;
		end else begin
			det_on_r <= det_on_nxt;
			ref_on_r <= ref_on_nxt;
		end
	end

	assign S_AXI_AWREADY = awready_r;
	assign S_AXI_WREADY = wready_r;
	assign S_AXI_BVALID = bvalid_r;
	assign S_AXI_BRESP = bresp_r;
	assign S_AXI_ARREADY = arready_r;
	assign S_AXI_RVALID = rvalid_r;
	assign S_AXI_RDATA = rdata_r;
	assign S_AXI_RRESP = rresp_r;
	assign DETECTOR_ON = det_on_r;
	assign REFERENCE_ON = ref_on_r;
	assign THRESHOLD_SEL = thr_r;
	assign WAKE_REQ = wake_r;
	assign IRQ = irq_r;
endmodule // supply_monitor_ctrl

// file: testbench/lvd_chk_assertions.sv
// Purpose: Port-level checks on the supply monitor control block
// Assumes: One clock domain, RST async active high
// Notes: Low-supply run counter saturates so long lows never wrap
module lvd_chk (
	input wire logic SYS_CLK,
	input wire logic RST,
	input wire lvd_pkg::resp_type S_AXI_BRESP,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic COMP_LOW,
	input wire logic SLEEP_MODE,
	input wire logic DETECTOR_ON,
	input wire logic REFERENCE_ON,
	input wire lvd_pkg::thr_type THRESHOLD_SEL,
	input wire logic WAKE_REQ
);
	timeunit 1ns;
	timeprecision 1ps;
	import lvd_pkg::*;
	logic [11:0] low_r;
	logic [11:0] low_nxt;
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (RST);
	// Cycles of continuous low supply
	always_comb begin
		low_nxt = 12'h000;
		if (COMP_LOW) low_nxt = (&low_r) ? low_r : low_r + 12'h001;
	end
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) low_r <= 12'h000;
		else low_r <= low_nxt;
	end
	chk_ref_with_det: assert property (DETECTOR_ON |-> REFERENCE_ON)
		else $error("reference off while detector on");
	chk_sleep_det_off: assert property (SLEEP_MODE [*2] |-> !DETECTOR_ON)
		else $error("detector on during sleep");
	chk_wake_pulse: assert property (WAKE_REQ |=> !WAKE_REQ)
		else $error("wake request longer than one cycle");
	chk_wake_delay: assert property (WAKE_REQ |-> low_r >= 12'h09C4)
		else $error("wake before the irq delay ran out");
	chk_read_upper: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:6] == 26'h0)
		else $error("upper read bits not zero");
	chk_thr_by_write: assert property ($changed(THRESHOLD_SEL) |->
		S_AXI_BVALID || $past(S_AXI_BVALID))
		else $error("threshold changed without a write");
	chk_b_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
		S_AXI_BVALID && $stable(S_AXI_BRESP))
		else $error("write response dropped early");
	chk_r_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
		S_AXI_RVALID && $stable(S_AXI_RDATA))
		else $error("read data dropped early");
endmodule // lvd_chk

bind supply_monitor_ctrl lvd_chk u_lvd_chk (.*);

// file: testbench/tb_low_supply_detector_ctrl.sv
// Purpose: Self-checking bench for the supply monitor control block
// Assumes: Bus handshakes sampled at the falling edge, driven at the rising edge
// Notes: Ready is raised one cycle late so the hold checks see a stall
module tb_low_supply_detector_ctrl;
	timeunit 1ns;
	timeprecision 1ps;
	import lvd_pkg::*;
	logic SYS_CLK, RST, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
	logic S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID;
	logic S_AXI_RREADY, COMP_LOW, SLEEP_MODE, IDLE_MODE, DETECTOR_ON, REFERENCE_ON;
	logic WAKE_REQ, IRQ;
	logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR;
	logic [31:0] S_AXI_WDATA, S_AXI_RDATA, d;
	logic [3:0] S_AXI_WSTRB;
	resp_type S_AXI_BRESP, S_AXI_RRESP, r;
	thr_type THRESHOLD_SEL;
	int err_count, tests_run, wakes, n;
	// Write data, read value, reference, detector
	logic [17:0] rows [9] = '{18'h0_0000, 18'h0_1C1C, 18'h0_2022, 18'h0_4447,
		18'h0_686B, 18'h3_8C0C, 18'h0_F073, 18'h0_585B, 18'h0_1414};

	supply_monitor_ctrl u_supply_monitor_ctrl (.*);

	initial begin
		SYS_CLK = 0;
		forever #2 SYS_CLK = ~SYS_CLK;
	end
	always @(posedge SYS_CLK) if (WAKE_REQ === 1'b1) wakes++;

	task automatic wrap_up;
		$display("checks %0d errors %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic at, wt, bt;
		int k;
		k = 0;
		@(posedge SYS_CLK);
		S_AXI_AWADDR <= a;
		S_AXI_WDATA <= v;
		S_AXI_AWVALID <= 1;
		S_AXI_WVALID <= 1;
		do begin
			@(negedge SYS_CLK);
			{at, wt, bt} = {S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID};
			r = S_AXI_BRESP;
			k++;
			@(posedge SYS_CLK);
			if (at) S_AXI_AWVALID <= 0;
			if (wt) S_AXI_WVALID <= 0;
			if (bt) S_AXI_BREADY <= 1;
		end while (bt !== 1'b1 && k < 40);
		@(posedge SYS_CLK);
		S_AXI_BREADY <= 0;
		// A response seen on the last allowed try is not a timeout
		if (bt !== 1'b1) begin
			err_count++;
			wrap_up();
		end
	endtask
	task automatic rd(input logic [7:0] a);
		logic at, vt;
		int k;
		k = 0;
		@(posedge SYS_CLK);
		S_AXI_ARADDR <= a;
		S_AXI_ARVALID <= 1;
		do begin
			@(negedge SYS_CLK);
			{at, vt, d, r} = {S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RDATA, S_AXI_RRESP};
			k++;
			@(posedge SYS_CLK);
			if (at) S_AXI_ARVALID <= 0;
			if (vt) S_AXI_RREADY <= 1;
		end while (vt !== 1'b1 && k < 40);
		@(posedge SYS_CLK);
		S_AXI_RREADY <= 0;
		if (vt !== 1'b1) begin
			err_count++;
			wrap_up();
		end
	endtask

	initial begin
		RST = 1;
		{S_AXI_AWADDR, S_AXI_AWVALID, S_AXI_WDATA, S_AXI_WVALID, S_AXI_BREADY} = '0;
		{S_AXI_ARADDR, S_AXI_ARVALID, S_AXI_RREADY, COMP_LOW, SLEEP_MODE, IDLE_MODE} = '0;
		S_AXI_WSTRB = 4'hF;
		repeat (2) @(posedge SYS_CLK);
		RST <= 0;
		// Reset values of control, status and mask
		for (n = 0; n < 3; n++) begin
			rd(8'(n * 4));
			chk("reset value", 0, d);
		end
		// Field decode per row, all eight threshold codes
		foreach (rows[i]) begin
			wr(8'h00, {24'h0, rows[i][17:10]});
			chk("write resp", 0, r);
			rd(8'h00);
			chk("read resp", 0, r);
			chk("control", {24'h0, rows[i][9:2]}, d);
			chk("threshold", rows[i][4:2], THRESHOLD_SEL);
			chk("reference", rows[i][1], REFERENCE_ON);
			chk("detector", rows[i][0], DETECTOR_ON);
		end
		// Unmapped address is refused without side effects
		wr(8'h0C, 32'h0000_00FF);
		chk("bresp", 2, r);
		rd(8'h0C);
		chk("rresp", 2, r);
		// Write without the low byte lane is answered but changes nothing
		S_AXI_WSTRB <= 4'hE;
		wr(8'h00, 32'h0000_0000);
		S_AXI_WSTRB <= 4'hF;
		chk("bresp lane", 0, r);
		rd(8'h00);
		chk("control kept", 5, d);
		// Sleep forces the detector off, reference stays on
		wr(8'h00, 32'h0000_0010);
		SLEEP_MODE <= 1;
		repeat (3) @(negedge SYS_CLK);
		chk("sleep detector", 0, DETECTOR_ON);
		chk("sleep reference", 1, REFERENCE_ON);
		@(posedge SYS_CLK) SLEEP_MODE <= 0;
		// Flag follows the comparator in both directions, unfiltered
		for (n = 1; n >= 0; n--) begin
			@(posedge SYS_CLK) COMP_LOW <= n[0];
			repeat (5) @(negedge SYS_CLK);
			rd(8'h00);
			chk("live flag", 32'h10 | (n << 5), d);
		end
		// Delayed interrupt wakes from idle and stays set
		wr(8'h08, 32'h0000_0001);
		rd(8'h04);
		@(posedge SYS_CLK) {COMP_LOW, IDLE_MODE} <= 2'b11;
		repeat (2400) @(negedge SYS_CLK);
		chk("early irq", 0, IRQ);
		for (n = 0; n < 400 && WAKE_REQ !== 1'b1; n++) @(negedge SYS_CLK);
		chk("wake seen", 1, n < 400);
		repeat (20) @(negedge SYS_CLK);
		chk("irq held", 1, IRQ);
		chk("one wake", 1, wakes);
		rd(8'h04);
		// Delay expiry and the fresh flag rise both stand in status
		chk("status set", 32'h0000_0003, d);
		rd(8'h04);
		chk("status cleared", 0, d);
		chk("irq cleared", 0, IRQ);
		// Preset flag masks new wake-ups, mask gates the line
		wr(8'h04, 32'h0000_0001);
		chk("preset irq", 1, IRQ);
		wr(8'h08, 32'h0000_0000);
		chk("masked irq", 0, IRQ);
		@(posedge SYS_CLK) COMP_LOW <= 0;
		repeat (5) @(posedge SYS_CLK);
		COMP_LOW <= 1;
		repeat (2700) @(negedge SYS_CLK);
		chk("no wake", 1, wakes);
		// Reset in mid-run returns the detector to off
		@(posedge SYS_CLK) RST <= 1;
		repeat (2) @(posedge SYS_CLK);
		RST <= 0;
		rd(8'h00);
		chk("rerun control", 0, d);
		chk("rerun detector", 0, DETECTOR_ON);
		wrap_up();
	end
endmodule // tb_low_supply_detector_ctrl
